// ### hdl/sbo_defines.svh
// Constants for the side-band output enable block.
`ifndef SBO_DEFINES_SVH
`define SBO_DEFINES_SVH
`define SBO_NUM_OUTPUTS 16
`define SBO_NUM_PINS 8
`define SBO_SHIFT_RESET_VAL 16'hFFFF
`define SBO_MASK_RESET_VAL 16'h0000
`define SBO_SMB_EN_RESET_VAL 16'hFFFF
`define SBO_PIN_D 3
`define SBO_PIN_E 4
`define SBO_PIN_G 6
`define SBO_PIN_H 7
`define SBO_MAX_SHIFT_MHZ 25
`define SBO_CLK_MHZ 40
`define SBO_SYNC_STAGES 2
`endif

// ### hdl/sbo_pkg.sv
// Types for the side-band output enable block.
package sbo_pkg;
  typedef enum logic [1:0] {
    SBO_STRAP_WAIT,
    SBO_STRAP_HELD
  } sbo_strap_state_t;
endpackage : sbo_pkg

// ### hdl/sbo_sync.sv
// Parameterised two-flop synchroniser for a vector of asynchronous levels.
`timescale 1ns/1ps
module sbo_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  // First stage; read only by the second stage.
  logic [WIDTH-1:0] meta_q;

  // Two stages in series keep metastability off the logic that follows.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= INIT;
      syncOut <= INIT;
    end else begin
      meta_q <= asyncIn;
      syncOut <= meta_q;
    end
  end
endmodule : sbo_sync

// ### hdl/sbo_sideband_output_enable.sv
// Output-enable control with strap-selected serial side-band interface.
// Behaviour
// - At most eight active-low enable pins.
// - Strap chooses enables or side-band on pins.
// - Small variants share pins via SMBus latch.
// - Strap 0: D,E,G,H enable outputs 6,8,12,14.
// - Two-output variant has no side-band.
// - Side-band shifts at up to 25 MHz; code samples it at 40 MHz, so shift clocks must stay below 20 MHz.
// - Side-band works before power-good.
// - Strap sampled at power-up, held static.
// - Strap 0 disables side-band completely.
// - Shift bit 1 enables, 0 disables.
// - Shift register resets to all ones.
// - Shifting uses only side-band clock.
// - Enables applied through glitch-free output synchroniser.
// - Mask bits reset to zero.
// - Mask 1 forces side-band enable.
// - Readback copy refreshed on strobe fall.
// - Shift register read-only over SMBus.
// - Output runs when all three permit.
// - Capture serial input on rising clock while strobe high.
// - Strobe fall loads output control register.
// - Strobe low ignores clock and data.
`timescale 1ns/1ps
`include "sbo_defines.svh"
module sbo_sideband_output_enable
  import sbo_pkg::*;
#(
  parameter int NUM_OUTPUTS = `SBO_NUM_OUTPUTS,
  parameter bit HAS_SIDEBAND = 1'b1
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic sidebandStrap,
  input wire logic powerGood,
  input wire logic [`SBO_NUM_PINS-1:0] outEnPin_n,
  output logic [`SBO_NUM_PINS-1:0] outEnPinOut,
  output logic [`SBO_NUM_PINS-1:0] outEnPinOe,
  input wire logic [NUM_OUTPUTS-1:0] smbusEnable,
  input wire logic [NUM_OUTPUTS-1:0] smbusMask,
  input wire logic smbusMaskWrite,
  input wire logic smbusSelectLatch_n,
  output logic [NUM_OUTPUTS-1:0] sidebandReadback,
  output logic [NUM_OUTPUTS-1:0] sidebandMask,
  output logic sidebandActive,
  input wire logic [NUM_OUTPUTS-1:0] refClockRun,
  output logic [NUM_OUTPUTS-1:0] outputRun
);
  localparam int SYNC_W = `SBO_NUM_PINS + 1;

  // Cycles per fastest half shift period; documents sampling margin.
  localparam int SHIFT_HALF_CYC = (`SBO_CLK_MHZ + 2 * `SBO_MAX_SHIFT_MHZ - 1)
                                  / (2 * `SBO_MAX_SHIFT_MHZ);

  // Synchronised pin and strap levels.
  logic [SYNC_W-1:0] syncIn;
  logic [`SBO_NUM_PINS-1:0] pinSync;
  logic strapSync;

  // Strap capture state.
  sbo_strap_state_t strapState_q;
  logic strapEn_q;
  // Edges seen since reset release; the strap is read only once the synchroniser holds it.
  logic [1:0] strapCnt_q;

  // Side-band pin roles after demultiplexing.
  logic shiftClk;
  logic serialIn;
  logic loadStrobe;
  logic shiftClkPrev_q;
  logic loadStrobePrev_q;
  logic shiftRise;
  logic loadFall;

  // Shift register, output control copy and mask.
  logic [NUM_OUTPUTS-1:0] shift_q;
  logic [NUM_OUTPUTS-1:0] ctrl_q;
  logic [NUM_OUTPUTS-1:0] mask_q;
  logic [NUM_OUTPUTS-1:0] pinEnable;
  logic [NUM_OUTPUTS-1:0] sbEnable;
  logic [NUM_OUTPUTS-1:0] run_q;

  // All pins pass two flops; the strap rides along with them.
  sbo_sync #(
    .WIDTH(SYNC_W),
    .INIT({1'b0, {`SBO_NUM_PINS{1'b1}}})
  ) u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .asyncIn({sidebandStrap, outEnPin_n}),
    .syncOut(syncIn)
  );

  assign pinSync = syncIn[`SBO_NUM_PINS-1:0];
  assign strapSync = syncIn[`SBO_NUM_PINS];

  // Maps an output index to the pin that gates it, or none.
  function automatic logic pinGate(input int idx, input logic [`SBO_NUM_PINS-1:0] pins,
                                   input logic strap, input logic smbSel_n);
    logic g;
    g = 1'b1;
    unique case (idx)
      0: g = !pins[0];
      2: g = !pins[1];
      4: g = !pins[2];
      6: g = strap ? 1'b1 : !pins[`SBO_PIN_D];
      8: g = strap ? 1'b1 : !pins[`SBO_PIN_E];
      10: g = !pins[5];
      12: g = (strap || !smbSel_n) ? 1'b1 : !pins[`SBO_PIN_G];
      14: g = strap ? 1'b1 : !pins[`SBO_PIN_H];
      default: g = 1'b1;
    endcase
    return g;
  endfunction : pinGate

  // Strap is caught once after reset release and then held for good.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      strapState_q <= SBO_STRAP_WAIT;
      strapEn_q <= 1'b0;
      strapCnt_q <= 2'h0;
    end else begin
      unique case (strapState_q)
        SBO_STRAP_WAIT: begin
          // Reading earlier would catch the synchroniser's reset value, not the pin.
          if (strapCnt_q == 2'(`SBO_SYNC_STAGES)) begin
            strapEn_q <= strapSync && HAS_SIDEBAND;
            strapState_q <= SBO_STRAP_HELD;
          end else begin
            strapCnt_q <= strapCnt_q + 2'h1;
          end
        end
        SBO_STRAP_HELD: begin
          strapState_q <= SBO_STRAP_HELD;
        end
      endcase
    end
  end

  assign shiftClk = strapEn_q & pinSync[`SBO_PIN_D];
  assign serialIn = pinSync[`SBO_PIN_E];
  assign loadStrobe = strapEn_q & pinSync[`SBO_PIN_G];

  // Edge history of the side-band clock and strobe.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      shiftClkPrev_q <= 1'b0;
      loadStrobePrev_q <= 1'b0;
    end else begin
      shiftClkPrev_q <= shiftClk;
      loadStrobePrev_q <= loadStrobe;
    end
  end

  assign shiftRise = shiftClk & ~shiftClkPrev_q & loadStrobe;
  assign loadFall = ~loadStrobe & loadStrobePrev_q;

  // Shift register runs independent of power-good and the reference clock.
  // rate bounded by sampling; 40 MHz sampling keeps edges apart for slow links.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      shift_q <= `SBO_SHIFT_RESET_VAL;
    end else if (shiftRise) begin
      shift_q <= {shift_q[NUM_OUTPUTS-2:0], serialIn};
    end
  end

  // Output control register and readback copy share the strobe fall.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q <= `SBO_SHIFT_RESET_VAL;
    end else if (loadFall) begin
      ctrl_q <= shift_q;
    end
  end

  assign sidebandReadback = ctrl_q;

  // Mask is written over SMBus once the power-good domain is alive.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mask_q <= `SBO_MASK_RESET_VAL;
    end else if (smbusMaskWrite && powerGood) begin
      mask_q <= smbusMask;
    end
  end

  assign sidebandMask = mask_q;
  assign sidebandActive = strapEn_q;

  // Per-output enable terms.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_OUTPUTS; gi++) begin : g_out
      assign pinEnable[gi] = pinGate(gi, pinSync, strapEn_q, smbusSelectLatch_n);
      assign sbEnable[gi] = !strapEn_q || ctrl_q[gi] || mask_q[gi];
    end
  endgenerate

  // Outputs change state only while their reference clock runs.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      run_q <= '0;
    end else begin
      for (int i = 0; i < NUM_OUTPUTS; i++) begin
        if (refClockRun[i]) begin
          run_q[i] <= sbEnable[i] & smbusEnable[i] & pinEnable[i];
        end
      end
    end
  end

  assign outputRun = run_q;

  // Pin H drives serial out in side-band mode only.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      outEnPinOut <= '0;
    end else begin
      outEnPinOut <= '0;
      outEnPinOut[`SBO_PIN_H] <= shift_q[NUM_OUTPUTS-1];
    end
  end

  always_comb begin
    outEnPinOe = '0;
    outEnPinOe[`SBO_PIN_H] = strapEn_q;
  end

  // Half period figure kept for reference in reviews of link timing.
  logic unusedHalf;
  assign unusedHalf = (SHIFT_HALF_CYC > 0);
endmodule : sbo_sideband_output_enable

// ### tb/sbo_chk.sv
// Port checker for the side-band output enable block.
`timescale 1ns/1ps
`include "sbo_defines.svh"
module sbo_chk #(
  parameter int NUM_OUTPUTS = 16
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic powerGood,
  input wire logic [`SBO_NUM_PINS-1:0] outEnPin_n,
  input wire logic [`SBO_NUM_PINS-1:0] outEnPinOut,
  input wire logic [`SBO_NUM_PINS-1:0] outEnPinOe,
  input wire logic [NUM_OUTPUTS-1:0] smbusEnable,
  input wire logic [NUM_OUTPUTS-1:0] smbusMask,
  input wire logic smbusMaskWrite,
  input wire logic [NUM_OUTPUTS-1:0] sidebandReadback,
  input wire logic [NUM_OUTPUTS-1:0] sidebandMask,
  input wire logic sidebandActive,
  input wire logic [NUM_OUTPUTS-1:0] refClockRun,
  input wire logic [NUM_OUTPUTS-1:0] outputRun
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Cycles the strobe pin has been low; saturates so it never wraps.
  logic [3:0] lowCnt_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) lowCnt_q <= 4'h0;
    else if (outEnPin_n[6]) lowCnt_q <= 4'h0;
    else if (lowCnt_q != 4'hF) lowCnt_q <= lowCnt_q + 4'h1;
  end
  sequence s_mask_req;
    smbusMaskWrite && powerGood;
  endsequence
  a_reset_vals: assert property ($rose(reset_n) |-> sidebandMask == '0 && &sidebandReadback)
    else $error("reset values wrong");
  a_strobe_fall: assert property ($changed(sidebandReadback) |-> lowCnt_q inside {[4'h1:4'h8]})
    else $error("readback moved away from strobe fall");
  a_strobe_ignore: assert property (sidebandActive && lowCnt_q > 4'h6 |-> $stable(outEnPinOut[7]))
    else $error("shift while strobe low");
  a_mask_refused: assert property (smbusMaskWrite && !powerGood |=> $stable(sidebandMask))
    else $error("mask written before power good");
  a_mask_load: assert property (s_mask_req |=> sidebandMask == $past(smbusMask))
    else $error("mask not loaded");
  a_strap_hold: assert property (sidebandActive |=> sidebandActive)
    else $error("strap changed");
  a_pins_idle: assert property (!sidebandActive |-> outEnPinOe == '0)
    else $error("pin driven without side-band");
  a_sout_drive: assert property (sidebandActive |-> outEnPinOe == 8'h80)
    else $error("serial out not driven");
  a_smb_gate: assert property ((outputRun & ~$past(smbusEnable) & $past(refClockRun)) == '0)
    else $error("output runs while bus disables it");
endmodule : sbo_chk
bind sbo_sideband_output_enable sbo_chk #(.NUM_OUTPUTS(NUM_OUTPUTS)) u_sbo_chk (.*);

// ### tb/sbo_ctrl_model.sv
// Behavioural side-band controller driving clock, data and strobe.
`timescale 1ns/1ps
module sbo_ctrl_model (
  output logic shiftClk,
  output logic serialIn,
  output logic shiftLoad_n
);
  initial begin
    shiftClk = 1'b0;
    serialIn = 1'b0;
    shiftLoad_n = 1'b0;
  end
  // highest bit first, clock parked low.
  task automatic sendFrame(input logic [15:0] v);
    shiftLoad_n = 1'b1;
    for (int i = 15; i >= 0; i--) begin
      serialIn = v[i];
      #100 shiftClk = 1'b1;
      #100 shiftClk = 1'b0;
    end
    // Released data shows the inverse so a late sample cannot pass.
    serialIn = ~v[0];
    #100 shiftLoad_n = 1'b0;
    #100;
  endtask : sendFrame
  // One clock pulse with the strobe low.
  task automatic strayPulse(input logic d);
    serialIn = d;
    #100 shiftClk = 1'b1;
    #100 shiftClk = 1'b0;
    serialIn = ~d;
  endtask : strayPulse
endmodule : sbo_ctrl_model

// ### tb/sbo_sideband_output_enable_tb.sv
// Self-checking bench for the side-band output enable block.
`timescale 1ns/1ps
module sbo_sideband_output_enable_tb;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic strap = 1'b1;
  logic powerGood = 1'b0;
  logic [7:0] tbPins = 8'h00;
  logic [15:0] smbEn = 16'hFFFF;
  logic [15:0] smbMask = 16'h0000;
  logic maskWr = 1'b0;
  logic smbSel_n = 1'b1;
  logic [15:0] refRun = 16'hFFFF;
  logic sClk, sIn, sLd_n, active;
  logic [7:0] pinOut, pinOe;
  logic [15:0] readback, mask, run;
  int n_errors = 0;
  int n_compared = 0;
  // Shared pins: side-band lines in strap mode, bench enables otherwise.
  wire [7:0] pinBus = {pinOe[7] ? pinOut[7] : tbPins[7], strap ? sLd_n : tbPins[6], tbPins[5],
    strap ? sIn : tbPins[4], strap ? sClk : tbPins[3], tbPins[2:0]};
  always #12.5 clk = ~clk;
  sbo_ctrl_model u_ctrl (.shiftClk(sClk), .serialIn(sIn), .shiftLoad_n(sLd_n));
  sbo_sideband_output_enable u_sbo_sideband_output_enable (.clk(clk), .reset_n(reset_n),
    .sidebandStrap(strap), .powerGood(powerGood), .outEnPin_n(pinBus), .outEnPinOut(pinOut),
    .outEnPinOe(pinOe), .smbusEnable(smbEn), .smbusMask(smbMask), .smbusMaskWrite(maskWr),
    .smbusSelectLatch_n(smbSel_n), .sidebandReadback(readback), .sidebandMask(mask),
    .sidebandActive(active), .refClockRun(refRun), .outputRun(run));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("compared=%0d errors=%0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic doReset(input logic s);
    strap = s;
    reset_n = 1'b0;
    cyc(20);
    reset_n = 1'b1;
    cyc(6);
  endtask : doReset
  // Bounded wait for the readback copy; a miss ends the run.
  task automatic waitRb(input logic [15:0] exp);
    int i;
    for (i = 0; i < 20 && readback !== exp; i++) cyc(1);
    chk(readback, exp);
    if (readback !== exp) report_and_stop();
  endtask : waitRb
  task automatic maskWrite(input logic [15:0] v);
    smbMask = v;
    maskWr = 1'b1;
    cyc(1);
    maskWr = 1'b0;
    cyc(3);
  endtask : maskWrite
  task automatic tShift;
    u_ctrl.sendFrame(16'hA5C3);
    waitRb(16'hA5C3);
    cyc(2);
    chk(run, 16'hA5C3);
    chk({15'h0, pinBus[7]}, 16'h0001);
    u_ctrl.sendFrame(16'h7F00);
    waitRb(16'h7F00);
    u_ctrl.strayPulse(1'b1);
    cyc(8);
    chk({15'h0, pinBus[7]}, 16'h0000);
  endtask : tShift
  task automatic tMask;
    maskWrite(16'hFFFF);
    chk(mask, 16'h0000);
    powerGood = 1'b1;
    cyc(1);
    maskWrite(16'hFFFF);
    chk(mask, 16'hFFFF);
    chk(run, 16'hFFFF);
  endtask : tMask
  task automatic tAnd;
    refRun = 16'h7FFF;
    smbEn = 16'h00FF;
    tbPins[0] = 1'b1;
    cyc(6);
    chk(run, 16'h80FE);
  endtask : tAnd
  task automatic tStrap0;
    smbEn = 16'hFFFF;
    refRun = 16'hFFFF;
    tbPins = 8'h48;
    doReset(1'b0);
    chk(run, 16'hEFBF);
    smbSel_n = 1'b0;
    cyc(4);
    chk(run, 16'hFFBF);
    smbSel_n = 1'b1;
    chk({15'h0, active}, 16'h0000);
    tbPins = 8'h40;
    repeat (3) begin
      tbPins[3] = 1'b1;
      cyc(4);
      tbPins[3] = 1'b0;
      cyc(4);
    end
    tbPins = 8'h00;
    cyc(8);
    chk(readback, 16'hFFFF);
    chk(run, 16'hFFFF);
  endtask : tStrap0
  initial begin
    doReset(1'b1);
    chk(readback, 16'hFFFF);
    chk({15'h0, active}, 16'h0001);
    chk(mask, 16'h0000);
    chk(run, 16'hFFFF);
    tShift();
    tMask();
    tAnd();
    tStrap0();
    report_and_stop();
  end
  initial begin
    #2000000;
    n_errors++;
    report_and_stop();
  end
endmodule : sbo_sideband_output_enable_tb
